// ===== inc/fcmd_defs.svh
// constants of the flash command host: register map, field positions,
// command bytes and bus timing; assumes a 4 ns core clock
`ifndef FCMD_DEFS_SVH
`define FCMD_DEFS_SVH

// register offsets (byte addresses, one aligned word each)
`define FCMD_OFF_CMD        8'h00
`define FCMD_OFF_ADDR       8'h04
`define FCMD_OFF_DATA       8'h08
`define FCMD_OFF_STAT       8'h0c
`define FCMD_OFF_CTRL       8'h10

// host status register fields
`define FCMD_ST_BUSY        0
`define FCMD_ST_REFUSED     1
`define FCMD_ST_ERR         2
`define FCMD_ST_RDY_PIN     3
`define FCMD_ST_ARRAY       4
`define FCMD_ST_SEQ_ERR     5
`define FCMD_ST_PROTECT     6
`define FCMD_ST_BYTE_LSB    8

// control register fields
`define FCMD_CTRL_PD        0

// device status byte fields
`define FCMD_SB_READY       7
`define FCMD_SB_ERASE_ERR   5
`define FCMD_SB_PROG_ERR    4
`define FCMD_SB_SUPPLY_ERR  3
`define FCMD_SB_SUSPENDED   2
`define FCMD_SB_PROTECT     1
`define FCMD_SB_ERR_MASK    8'h3a
`define FCMD_SB_RSVD_MASK   8'hfe

// command bytes
`define FCMD_CMD_READ_ARRAY 8'hff
`define FCMD_CMD_READ_STAT  8'h70
`define FCMD_CMD_CLR_STAT   8'h50
`define FCMD_CMD_ERASE_SET  8'h30
`define FCMD_CMD_CONFIRM    8'hd0
`define FCMD_CMD_SUSPEND    8'hb0
`define FCMD_CMD_LOCK_SET   8'h60
`define FCMD_CMD_BLOCK_LOCK 8'h01
`define FCMD_CMD_PERM_LOCK  8'hf1

// bus timing in ns and derived cycle counts (least times round up)
`define FCMD_CLK_PERIOD_NS  4
`define FCMD_T_WE_NS        50
`define FCMD_T_RD_NS        90
`define FCMD_T_GAP_NS       30
`define FCMD_CYC(ns)        (((ns) + `FCMD_CLK_PERIOD_NS - 1) / `FCMD_CLK_PERIOD_NS)

`endif

// ===== inc/fcmd_pkg.sv
// types of the flash command host: operation codes, states, read kinds
// assumes nothing beyond a SystemVerilog elaborator
package fcmd_pkg;

   // operations that software starts through the command register
   typedef enum logic [3:0]
   {
      OP_READ_ARRAY  = 4'h0,
      OP_READ_STATUS = 4'h1,
      OP_CLEAR_STAT  = 4'h2,
      OP_CHIP_ERASE  = 4'h3,
      OP_SUSPEND     = 4'h4,
      OP_RESUME      = 4'h5,
      OP_BLOCK_LOCK  = 4'h6,
      OP_PERM_LOCK   = 4'h7,
      OP_CLEAR_LOCKS = 4'h8,
      OP_READ_DATA   = 4'h9
   } fcmd_op_t;

   // sequencer states, one-hot
   typedef enum logic [4:0]
   {
      ST_IDLE = 5'b00001,
      ST_WR   = 5'b00010,
      ST_RD   = 5'b00100,
      ST_EVAL = 5'b01000,
      ST_WAIT = 5'b10000
   } fcmd_state_t;

   // what follows the command bytes
   typedef enum logic [1:0]
   {
      RD_NONE = 2'h0,
      RD_STAT = 2'h1,
      RD_POLL = 2'h2,
      RD_DATA = 2'h3
   } fcmd_rd_t;

   // byte sequence of one operation
   typedef struct packed
   {
      logic [7:0] b0;
      logic [7:0] b1;
      logic [1:0] n;
      fcmd_rd_t   rd;
      logic       ok;
   } fcmd_seq_t;

endpackage

// ===== hw/fcmd_host.sv
// flash command host: axi4-lite register slave that sequences command
// bytes, status polling and array reads on a parallel flash bus
// assumes flash pins synchronous to core_clk, dq wire resolved outside
//
// Notes on behaviour
// - chip erase: 30H then D0H, any address
// - after any error clear status before retrying
// - FFH restores array mode before array reads
// - B0H suspends, poll ready, D0H resumes
// - lock: 60H then 01H block, F1H permanent
// - several lock sets, one status check after; the host checks status after each
// - clear all locks: 60H then D0H
// - hold reset/power-down low while power unstable
// - reserved lowest status bit masked when polling
`timescale 1ns/1ps
`include "fcmd_defs.svh"

module fcmd_host
#(
   parameter int AXI_AW = 8,
   parameter int FL_AW  = 20,
   parameter int FL_DW  = 16,
   parameter int WE_CYC = `FCMD_CYC(`FCMD_T_WE_NS),
   parameter int RD_CYC = `FCMD_CYC(`FCMD_T_RD_NS),
   parameter int GAP_CYC = `FCMD_CYC(`FCMD_T_GAP_NS)
)
(
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              arst_n,
   // axi4-lite write channels
   input  wire logic [AXI_AW-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read channels
   input  wire logic [AXI_AW-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // system power
   input  wire logic              system_power_ok,
   // flash pins
   output logic [FL_AW-1:0]       flash_addr,
   output logic                   flash_ce_n,
   output logic                   flash_oe_n,
   output logic                   flash_we_n,
   output logic                   reset_powerdown_n,
   input  wire logic [FL_DW-1:0]  flash_dq_i,
   output logic [FL_DW-1:0]       flash_dq_o,
   output logic                   flash_dq_oe,
   input  wire logic              ready_busy_n
);
   import fcmd_pkg::*;

   localparam logic [7:0] WE_END  = 8'(WE_CYC);
   localparam logic [7:0] WR_END  = 8'(WE_CYC + GAP_CYC);
   localparam logic [7:0] RD_END  = 8'(RD_CYC);
   localparam logic [7:0] RDG_END = 8'(RD_CYC + GAP_CYC);

   fcmd_state_t       st_q;
   fcmd_op_t          op_q;
   fcmd_rd_t          rd_mode_q;
   logic [7:0]        cnt_q;
   logic [7:0]        b0_q, b1_q;
   logic [1:0]        n_q;
   logic [7:0]        last_wr_q, prev_wr_q;
   logic [FL_DW-1:0]  rd_buf_q, data_q;
   logic [7:0]        last_status_q;
   logic              err_pending_q, array_mode_q, refused_q, pd_req_q;
   logic [FL_AW-1:0]  addr_reg_q;
   logic              aw_got_q, w_got_q;
   logic [AXI_AW-1:0] aw_addr_q;
   logic [31:0]       w_data_q;
   logic [3:0]        w_strb_q;
   logic              wr_fire, cmd_req, start_ok;
   fcmd_seq_t         seq;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // merge written bytes into an old register value
   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            r[i*8 +: 8] = new_v[i*8 +: 8];
      end
      return r;
   endfunction

   // byte sequence of an operation; array reads prefix FFH if needed
   function automatic fcmd_seq_t seq_of(input logic [3:0] op, input logic in_array);
      fcmd_seq_t s;
      s = '{b0: `FCMD_CMD_READ_ARRAY, b1: 8'h00, n: 2'h1, rd: RD_NONE, ok: 1'b1};
      case (op)
         OP_READ_ARRAY:  s.n = 2'h1;
         OP_READ_STATUS: s = '{`FCMD_CMD_READ_STAT, 8'h00, 2'h1, RD_STAT, 1'b1};
         OP_CLEAR_STAT:  s.b0 = `FCMD_CMD_CLR_STAT;
         OP_CHIP_ERASE:  s = '{`FCMD_CMD_ERASE_SET, `FCMD_CMD_CONFIRM, 2'h2, RD_POLL, 1'b1};
         OP_SUSPEND:     s = '{`FCMD_CMD_SUSPEND, 8'h00, 2'h1, RD_POLL, 1'b1};
         OP_RESUME:      s.b0 = `FCMD_CMD_CONFIRM;
         OP_BLOCK_LOCK:  s = '{`FCMD_CMD_LOCK_SET, `FCMD_CMD_BLOCK_LOCK, 2'h2, RD_POLL, 1'b1};
         OP_PERM_LOCK:   s = '{`FCMD_CMD_LOCK_SET, `FCMD_CMD_PERM_LOCK, 2'h2, RD_POLL, 1'b1};
         OP_CLEAR_LOCKS: s = '{`FCMD_CMD_LOCK_SET, `FCMD_CMD_CONFIRM, 2'h2, RD_POLL, 1'b1};
         OP_READ_DATA:   s = '{`FCMD_CMD_READ_ARRAY, 8'h00, in_array ? 2'h0 : 2'h1, RD_DATA,
                               1'b1};
         default:        s.ok = 1'b0;
      endcase
      return s;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave: address and data taken in either order

   assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
   assign cmd_req = wr_fire && (aw_addr_q[7:0] == `FCMD_OFF_CMD);
   assign seq     = seq_of(w_data_q[3:0], array_mode_q);
   // an error blocks everything except status reads, clears and FFH
   assign start_ok = cmd_req && w_strb_q[0] && seq.ok && st_q == ST_IDLE
                     && reset_powerdown_n
                     && (!err_pending_q || w_data_q[3:0] == OP_CLEAR_STAT
                         || w_data_q[3:0] == OP_READ_STATUS
                         || w_data_q[3:0] == OP_READ_ARRAY);

   // write channel handshakes; ready drops once a beat is held
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         aw_got_q      <= 1'b0;
         w_got_q       <= 1'b0;
         aw_addr_q     <= '0;
         w_data_q      <= 32'h0000_0000;
         w_strb_q      <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got_q      <= 1'b1;
            aw_addr_q     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got_q      <= 1'b1;
            w_data_q     <= s_axi_wdata;
            w_strb_q     <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire)
         begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (aw_addr_q[7:0])
               `FCMD_OFF_CMD, `FCMD_OFF_ADDR, `FCMD_OFF_DATA,
               `FCMD_OFF_STAT, `FCMD_OFF_CTRL: s_axi_bresp <= 2'h0;
               default:                        s_axi_bresp <= 2'h2;
            endcase
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // software registers: address, power-down request, refused flag
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         addr_reg_q <= '0;
         pd_req_q   <= 1'b0;
         refused_q  <= 1'b0;
      end
      else
      begin
         if (wr_fire && aw_addr_q[7:0] == `FCMD_OFF_ADDR)
            addr_reg_q <= FL_AW'(merge(32'(addr_reg_q), w_data_q, w_strb_q));
         if (wr_fire && aw_addr_q[7:0] == `FCMD_OFF_CTRL && w_strb_q[0])
            pd_req_q <= w_data_q[`FCMD_CTRL_PD];
         // a refusal in the clearing cycle wins, so none goes unseen
         if (cmd_req && !start_ok)
            refused_q <= 1'b1;
         else if (wr_fire && aw_addr_q[7:0] == `FCMD_OFF_STAT && w_strb_q[0]
                  && w_data_q[`FCMD_ST_REFUSED])
            refused_q <= 1'b0;
      end
   end

   // read channel; data registered on the address handshake
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'h0;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= 2'h0;
         case (s_axi_araddr[7:0])
            `FCMD_OFF_CMD:  s_axi_rdata <= {28'h0, op_q};
            `FCMD_OFF_ADDR: s_axi_rdata <= 32'(addr_reg_q);
            `FCMD_OFF_DATA: s_axi_rdata <= 32'(data_q);
            `FCMD_OFF_STAT: s_axi_rdata <= {16'h0, last_status_q, 1'b0,
                                            last_status_q[`FCMD_SB_PROTECT],
                                            &last_status_q[5:4],
                                            array_mode_q, ready_busy_n, err_pending_q,
                                            refused_q, st_q != ST_IDLE};
            `FCMD_OFF_CTRL: s_axi_rdata <= {31'h0, pd_req_q};
            default:
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= 2'h2;
            end
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // power-down pin: low in reset and whenever power is not good

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         reset_powerdown_n <= 1'b0;
      else
         reset_powerdown_n <= system_power_ok && !pd_req_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer: command byte writes, status polls and array reads

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_q          <= ST_IDLE;
         op_q          <= OP_READ_ARRAY;
         rd_mode_q     <= RD_NONE;
         cnt_q         <= 8'h00;
         b0_q          <= 8'h00;
         b1_q          <= 8'h00;
         n_q           <= 2'h0;
         last_wr_q     <= 8'h00;
         prev_wr_q     <= 8'h00;
         rd_buf_q      <= '0;
         data_q        <= '0;
         last_status_q <= 8'h80;
         err_pending_q <= 1'b0;
         array_mode_q  <= 1'b1;
         flash_addr    <= '0;
         flash_ce_n    <= 1'b1;
         flash_oe_n    <= 1'b1;
         flash_we_n    <= 1'b1;
         flash_dq_o    <= '0;
         flash_dq_oe   <= 1'b0;
      end
      else
      begin
         case (st_q)
            ST_IDLE:
            begin
               cnt_q <= 8'h00;
               // a device held in reset comes back in array mode
               if (!reset_powerdown_n)
                  array_mode_q <= 1'b1;
               if (start_ok)
               begin
                  op_q       <= fcmd_op_t'(w_data_q[3:0]);
                  b0_q       <= seq.b0;
                  b1_q       <= seq.b1;
                  n_q        <= seq.n;
                  rd_mode_q  <= seq.rd;
                  flash_addr <= addr_reg_q;
                  st_q       <= (seq.n != 2'h0) ? ST_WR : ST_RD;
               end
            end
            ST_WR:
            begin
               cnt_q <= cnt_q + 8'h01;
               if (cnt_q == 8'h00)
               begin
                  flash_ce_n   <= 1'b0;
                  flash_we_n   <= 1'b0;
                  flash_dq_oe  <= 1'b1;
                  flash_dq_o   <= FL_DW'(b0_q);
                  prev_wr_q    <= last_wr_q;
                  last_wr_q    <= b0_q;
                  array_mode_q <= (b0_q == `FCMD_CMD_READ_ARRAY);
               end
               if (cnt_q == WE_END)
               begin
                  flash_we_n <= 1'b1;
                  flash_ce_n <= 1'b1;
               end
               if (cnt_q == WR_END)
               begin
                  flash_dq_oe <= 1'b0;
                  cnt_q       <= 8'h00;
                  b0_q        <= b1_q;
                  n_q         <= n_q - 2'h1;
                  if (n_q == 2'h1)
                  begin
                     // clearing status also ends the host's error hold
                     if (op_q == OP_CLEAR_STAT)
                        err_pending_q <= 1'b0;
                     case (rd_mode_q)
                        RD_NONE: st_q <= ST_IDLE;
                        RD_POLL: st_q <= ST_WAIT;
                        default: st_q <= ST_RD;
                     endcase
                  end
               end
            end
            ST_WAIT:
            begin
               // the pin saves reads, the polled ready bit still decides
               cnt_q <= 8'h00;
               if (ready_busy_n)
                  st_q <= ST_RD;
            end
            ST_RD:
            begin
               cnt_q <= cnt_q + 8'h01;
               if (cnt_q == 8'h00)
               begin
                  flash_ce_n <= 1'b0;
                  flash_oe_n <= 1'b0;
               end
               if (cnt_q == RD_END)
               begin
                  rd_buf_q   <= flash_dq_i;
                  flash_ce_n <= 1'b1;
                  flash_oe_n <= 1'b1;
               end
               if (cnt_q == RDG_END)
               begin
                  cnt_q <= 8'h00;
                  st_q  <= ST_EVAL;
               end
            end
            ST_EVAL:
            begin
               if (rd_mode_q == RD_DATA)
               begin
                  data_q <= rd_buf_q;
                  st_q   <= ST_IDLE;
               end
               else
               begin
                  last_status_q <= rd_buf_q[7:0] & `FCMD_SB_RSVD_MASK;
                  if (rd_mode_q == RD_POLL && !rd_buf_q[`FCMD_SB_READY])
                     st_q <= ST_WAIT;
                  else
                  begin
                     // device bits accumulate; the host holds until cleared
                     if ((rd_buf_q[7:0] & `FCMD_SB_ERR_MASK) != 8'h00)
                        err_pending_q <= 1'b1;
                     st_q <= ST_IDLE;
                  end
               end
            end
            default:
               st_q <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   a_erase_confirm_pair: assert property (@(posedge core_clk) disable iff (!arst_n)
      ($fell(flash_we_n) && op_q == OP_CHIP_ERASE && flash_dq_o[7:0] == `FCMD_CMD_CONFIRM)
      |-> prev_wr_q == `FCMD_CMD_ERASE_SET)
      else $error("chip erase confirm without setup");

   a_lock_confirm_pair: assert property (@(posedge core_clk) disable iff (!arst_n)
      ($fell(flash_we_n) && (flash_dq_o[7:0] == `FCMD_CMD_BLOCK_LOCK
                             || flash_dq_o[7:0] == `FCMD_CMD_PERM_LOCK))
      |-> prev_wr_q == `FCMD_CMD_LOCK_SET && op_q inside {OP_BLOCK_LOCK, OP_PERM_LOCK})
      else $error("lock confirm without lock setup");

   a_unlock_pair: assert property (@(posedge core_clk) disable iff (!arst_n)
      ($fell(flash_we_n) && op_q == OP_CLEAR_LOCKS && flash_dq_o[7:0] == `FCMD_CMD_CONFIRM)
      |-> prev_wr_q == `FCMD_CMD_LOCK_SET)
      else $error("lock clear confirm without setup");

   a_suspend_resume: assert property (@(posedge core_clk) disable iff (!arst_n)
      ($fell(flash_we_n) && op_q inside {OP_SUSPEND, OP_RESUME})
      |-> flash_dq_o[7:0] == (op_q == OP_SUSPEND ? `FCMD_CMD_SUSPEND : `FCMD_CMD_CONFIRM))
      else $error("wrong suspend or resume byte");

   a_oe_no_drive: assert property (@(posedge core_clk) disable iff (!arst_n)
      !flash_oe_n |-> !flash_dq_oe && !flash_ce_n && flash_we_n)
      else $error("data driven during output enable");

   a_error_refuse: assert property (@(posedge core_clk) disable iff (!arst_n)
      (cmd_req && err_pending_q && st_q == ST_IDLE
       && w_data_q[3:0] inside {OP_CHIP_ERASE, OP_BLOCK_LOCK, OP_PERM_LOCK, OP_CLEAR_LOCKS})
      |=> st_q == ST_IDLE ##1 st_q == ST_IDLE)
      else $error("operation started while error pending");

   a_array_before_read: assert property (@(posedge core_clk) disable iff (!arst_n)
      (st_q == ST_RD && rd_mode_q == RD_DATA && !flash_oe_n) |-> array_mode_q)
      else $error("array read outside array mode");

   a_poll_not_ready: assert property (@(posedge core_clk) disable iff (!arst_n)
      (st_q == ST_EVAL && rd_mode_q == RD_POLL && !rd_buf_q[`FCMD_SB_READY])
      |=> st_q == ST_WAIT && err_pending_q == $past(err_pending_q))
      else $error("busy status not polled again");

   a_power_low: assert property (@(posedge core_clk) disable iff (!arst_n)
      !system_power_ok |=> !reset_powerdown_n [*1] ##0 (st_q != ST_IDLE || !start_ok))
      else $error("power-down pin not asserted");

   a_reserved_masked: assert property (@(posedge core_clk) disable iff (!arst_n)
      $changed(last_status_q) |-> !last_status_q[0] && $past(st_q) == ST_EVAL)
      else $error("reserved status bit not masked");

endmodule // fcmd_host

// ===== verification/fcmd_flash_model.sv
// flash device model: command decode, status byte, busy time, array data
// assumes the bench feeds it the resolved data wire and the fault inputs
`timescale 1ns/1ps
module fcmd_flash_model
(
   // host pins
   input  wire logic [19:0] addr,
   input  wire logic        ce_n, oe_n, we_n, rp_n,
   input  wire logic [15:0] dq_w,
   output logic [15:0]      dq_r,
   output logic             ready_busy_n,
   // faults the bench commands
   input  wire logic        fail, all_locked
);
   logic [7:0] sr, prev, b;
   logic       stat_md, perm;
   logic       tgl = 1'b0;
   always #4 tgl = ~tgl;
   // deselected: a moving pattern, never the last value
   assign dq_r = (!ce_n && !oe_n && rp_n) ? (stat_md ? {8'h00, sr} : addr[15:0] ^ 16'h1234)
                 : {16{tgl}} ^ 16'h5aa5;
   // commands latch when the first of ce_n and we_n rises; the host lifts both on one edge
   wire        wr_on = !(ce_n || we_n) && rp_n === 1'b1;
   always @(negedge wr_on or negedge rp_n)
   begin
      if (!rp_n)
      begin
         {sr, prev, stat_md, perm, ready_busy_n} = {16'h8000, 3'b001};
      end
      else if (prev != 8'h00)
      begin
         b = dq_w[7:0];
         stat_md = 1'b1;
         if (b != 8'hd0 && !(prev == 8'h60 && (b == 8'h01 || b == 8'hf1)))
            sr[5:4] = 2'b11;
         else if (prev == 8'h60 && perm && b != 8'hf1 || prev == 8'h30 && all_locked)
            sr[1] = 1'b1;
         else if (fail)
            sr[b == 8'hd0 ? 5 : 4] = 1'b1;
         else
            perm = perm | (b == 8'hf1);
         prev = 8'h00;
         // no strobes come while busy, so the delay blocks nothing
         // the pin lags the strobe, so an early poll reads a busy status
         sr[7] = 1'b0;
         #20;
         ready_busy_n = 1'b0;
         #60;
         {sr[7], ready_busy_n} = 2'b11;
      end
      else
      begin
         case (dq_w[7:0])
            8'hff: stat_md = 1'b0;
            8'h70: stat_md = 1'b1;
            8'h50: sr = sr & 8'hc5;
            8'hb0: {stat_md, sr[2]} = 2'b11;
            8'hd0: sr[2] = 1'b0;
            default: prev = dq_w[7:0];
         endcase
      end
   end
endmodule // fcmd_flash_model

// ===== verification/tb_flash_erase_lock_command_unit.sv
// bench: axi4-lite master tasks, a row table of operations, hand tests
// assumes the flash model and the design files are compiled first
`timescale 1ns/1ps
module tb_flash_erase_lock_command_unit;
   logic        core_clk = 1'b0, arst_n = 1'b0, pwr = 1'b1, fail = 1'b0, alk = 1'b0;
   logic        awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
   logic [7:0]  awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, st;
   logic [1:0]  r;
   wire         awr, wr, bv, arr, rv, ce_n, oe_n, we_n, rp_n, dq_oe, rb_n;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [19:0] fa;
   wire  [15:0] dq_o, dq_r;
   wire  [15:0] dq = dq_oe ? dq_o : dq_r;
   int          num_errors = 0, checks = 0;
   // {op, 00, fail, all locked, status byte expected}
   logic [15:0] rows [11] = '{16'h3080, 16'h32a0, 16'h3182, 16'h6080, 16'h6290, 16'h82a0,
                              16'h7080, 16'h6082, 16'h8082, 16'h4084, 16'h5080};
   always #2 core_clk = ~core_clk;
   fcmd_host #(.WE_CYC(2), .RD_CYC(3), .GAP_CYC(1)) dut (.core_clk(core_clk),
      .arst_n(arst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
      .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(rrdy), .system_power_ok(pwr), .flash_addr(fa),
      .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .reset_powerdown_n(rp_n),
      .flash_dq_i(dq), .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .ready_busy_n(rb_n));
   fcmd_flash_model dev (.addr(fa), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .rp_n(rp_n),
      .dq_w(dq), .dq_r(dq_r), .ready_busy_n(rb_n), .fail(fail), .all_locked(alk));
   task automatic final_report;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // each channel released at its own handshake; bready held until bvalid
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      {awa, wd, awv, wv, brdy} <= {a, d, 3'b111};
      do
      begin
         @(posedge core_clk);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
      end
      while (!bv);
      r = bresp;
      brdy <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a);
      @(posedge core_clk);
      {ara, arv, rrdy} <= {a, 2'b11};
      do
      begin
         @(posedge core_clk);
         if (arr) arv <= 1'b0;
      end
      while (!rv);
      {st, r} = {rdata, rresp};
      rrdy <= 1'b0;
   endtask
   // start an operation and poll busy, bounded
   task automatic cmd(input logic [3:0] op);
      axw(8'h00, {28'h0, op});
      st[0] = 1'b1;
      for (int k = 0; k < 500 && st[0] !== 1'b0; k++)
         axr(8'h0c);
      chk(st[0], 1'b0);
   endtask
   // a driving host must never meet an enabled device output
   always @(posedge core_clk)
      if (arst_n && !oe_n && dq_oe)
         chk(1'b1, 1'b0);
   initial
   begin
      #200000;
      num_errors++;
      final_report;
   end
   initial
   begin
      repeat (5) @(posedge core_clk);
      arst_n <= 1'b1;
      axr(8'h0c);
      chk({st[15:8], st[0]}, 9'h100);
      foreach (rows[i])
      begin
         {fail, alk} <= rows[i][9:8];
         cmd(rows[i][15:12]);
         cmd(4'h1);
         chk({st[15:8], st[6]}, {rows[i][7:0], rows[i][1]});
         cmd(4'h3);
         chk({st[15:8], st[1]}, {rows[i][7:0], |(rows[i][7:0] & 8'h3a)});
         cmd(4'h2);
         axw(8'h0c, 32'h2);
         cmd(4'h1);
         chk({st[15:8], st[1]}, {rows[i][7:0] & 8'hc5, 1'b0});
      end
      axw(8'h04, 32'habcd);
      cmd(4'h9);
      axr(8'h08);
      chk(st[15:0], 16'hb9f9);
      axw(8'h04, 32'h12);
      cmd(4'h9);
      axr(8'h08);
      chk(st[15:0], 16'h1226);
      axr(8'h20);
      chk({st[29:0], r}, 32'h2);
      axw(8'h24, 32'h0);
      chk(r, 2'h2);
      pwr <= 1'b0;
      repeat (3) @(posedge core_clk);
      axw(8'h00, 32'h0);
      axr(8'h0c);
      chk({st[1], rp_n}, 2'b10);
      pwr <= 1'b1;
      axw(8'h0c, 32'h2);
      axw(8'h10, 32'h1);
      axr(8'h10);
      chk({st[0], rp_n}, 2'b10);
      final_report;
   end
endmodule // tb_flash_erase_lock_command_unit
